// ---- bench/tb.sv ----
// Bench for the pattern output unit: Wishbone tasks, timer model, self-checks.
// Assumes the checker binds itself to tpo_top from its own file.
`timescale 1ns/1ns
`include "tpo_regs.svh"
module tb;
  logic sys_clk = 0, rst_n = 0, hw_standby = 0, cyc = 0, stb = 0, we = 0, nov = 0, rerr;
  logic [31:0] adr = 0, wdat = 0, rdat, dat_o;
  logic [15:0] dir = 0, pin_o, pin_oe;
  logic [2:0] start = 0, cmp_a, cmp_b;
  logic ack, err;
  int err_count = 0, check_count = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  tpo_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .hw_standby(hw_standby), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .cmp_a_pulse(cmp_a),
    .cmp_b_pulse(cmp_b), .port_low_dir(dir[7:0]), .port_high_dir(dir[15:8]),
    .pattern_pin_i(16'h0000), .pattern_pin_o(pin_o), .pattern_pin_oe(pin_oe));
  tpo_timer_model tm_u (.sys_clk(sys_clk), .start(start), .nov(nov), .timer_cmp_b(8'h04),
    .timer_cmp_a(8'h03), .cmp_a(cmp_a), .cmp_b(cmp_b));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge sys_clk); while (ack !== 1'b1 && err !== 1'b1);
    rdat = dat_o;
    rerr = err;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
    bus(1'h0, a, 8'h00);
    chk(n, e, rdat);
  endtask
  task automatic go(input logic [2:0] c, input logic b);
    start <= c;
    nov <= b;
    @(posedge sys_clk);
    start <= 3'h0;
  endtask
  // Port data follows on the edge that ends the pulse cycle
  task automatic ev(input logic b, input logic [15:0] e);
    do @(negedge sys_clk); while (!(|(b ? cmp_b : cmp_a)));
    @(negedge sys_clk);
    chk("pins", 32'(e), 32'(pin_o));
    @(posedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(`TPO_OFS_MODE, 32'h0000_00f0, "mode");
    rd(`TPO_OFS_TRIG, 32'h0000_00ff, "trig");
    bus(1'h1, `TPO_OFS_MODE, 8'h05);
    rd(`TPO_OFS_MODE, 32'h0000_00f5, "mode");
    $display("register test done");
    dir <= 16'hffff;
    bus(1'h1, `TPO_OFS_TRIG, 8'h1b);
    bus(1'h1, `TPO_OFS_EN_LO, 8'hff);
    bus(1'h1, `TPO_OFS_EN_HI, 8'hff);
    bus(1'h1, `TPO_OFS_NEXT_LO, 8'ha5);
    bus(1'h1, `TPO_OFS_NEXT_HI, 8'h3c);
    go(3'h4, 1'h0);
    ev(1'h0, 16'h00a5);
    go(3'h2, 1'h0);
    ev(1'h0, 16'h0ca5);
    go(3'h1, 1'h0);
    ev(1'h0, 16'h3ca5);
    chk("oe", 32'h0000_ffff, 32'(pin_oe));
    $display("trigger test done");
    bus(1'h1, `TPO_OFS_NEXT_LO, 8'h5a);
    go(3'h4, 1'h1);
    ev(1'h1, 16'h3ca0);
    ev(1'h0, 16'h3c5a);
    $display("overlap test done");
    bus(1'h1, `TPO_OFS_EN_LO, 8'h0f);
    bus(1'h1, `TPO_OFS_NEXT_LO, 8'hff);
    go(3'h4, 1'h0);
    ev(1'h0, 16'h3c5f);
    bus(1'h1, `TPO_OFS_PORT_LO, 8'h00);
    rd(`TPO_OFS_PORT_LO, 32'h0000_000f, "port");
    rd(32'h0000_0020, 32'h0000_0000, "gap");
    chk("err", 32'h0000_0001, 32'(rerr));
    hw_standby <= 1'h1;
    @(posedge sys_clk);
    hw_standby <= 1'h0;
    rd(`TPO_OFS_MODE, 32'h0000_00f0, "mode");
    $display("misc test done");
    results();
  end
endmodule // tb

// ---- bench/tpo_chk.sv ----
// Checker for bus answers and pattern pins of the pattern output unit.
// Assumes one sys_clk domain; bound to tpo_top below.
`timescale 1ns/1ns
module tpo_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [2:0] cmp_a_pulse,
  input wire logic [2:0] cmp_b_pulse,
  input wire logic [7:0] port_low_dir,
  input wire logic [7:0] port_high_dir,
  input wire logic [15:0] pattern_pin_o,
  input wire logic [15:0] pattern_pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Writes may legally move the pins, so they are excluded below
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  answer_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no answer");
  mode_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 0
    |-> wb_dat_o[7:4] == 4'hf) else $error("mode upper bits");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0) else $error("read upper");
  oe_dir_a: assert property (1 |=> pattern_pin_oe == $past({port_high_dir, port_low_dir}))
    else $error("oe");
  pin_cause_a: assert property ($changed(pattern_pin_o)
    |-> $past(|{cmp_a_pulse, cmp_b_pulse, hw_standby, wr})) else $error("pin moved");
  no_rise_a: assert property (!(|cmp_a_pulse) && !wr
    |=> (pattern_pin_o & ~$past(pattern_pin_o)) == 0) else $error("rise without A");
  standby_clear_a: assert property (hw_standby |=> pattern_pin_o == 0)
    else $error("standby");
endmodule // tpo_chk
bind tpo_top tpo_chk chk_u (.*);

// ---- bench/tpo_timer_model.sv ----
// Timer channel model: one-shot compare A pulse per start mask, preceded by a B pulse when nov is set.
// Assumes start is a one-cycle channel mask and compare values are small.
`timescale 1ns/1ns
module tpo_timer_model (
  input wire logic sys_clk,
  input wire logic [2:0] start,
  input wire logic nov,
  input wire logic [7:0] timer_cmp_b,
  input wire logic [7:0] timer_cmp_a,
  output logic [2:0] cmp_a,
  output logic [2:0] cmp_b
);
  logic [2:0] ch = 3'h0;
  logic [7:0] cnt = 8'h00;
  always @(posedge sys_clk) begin
    cmp_a <= 3'h0;
    cmp_b <= 3'h0;
    if (|start) begin
      ch <= start;
      cnt <= 8'h01;
    end else if (cnt != 8'h00) begin
      cnt <= cnt + 8'h01;
      // Counter runs through B and clears on A, so A comes the timer_cmp_a margin after B
      if (nov && cnt == timer_cmp_b) cmp_b <= ch;
      if (cnt == (nov ? timer_cmp_b + timer_cmp_a : timer_cmp_a)) begin
        cmp_a <= ch;
        cnt <= 8'h00;
      end
    end
  end
endmodule // tpo_timer_model

// ---- hdl/tpo_pkg.sv ----
// Types shared by the timing pattern output unit.
// Assumes nothing beyond a SystemVerilog compiler.
package tpo_pkg;
  typedef enum logic [1:0] {
    tpo_trig_ch0 = 2'b00,
    tpo_trig_ch1 = 2'b01,
    tpo_trig_ch2 = 2'b10,
    tpo_trig_ch2b = 2'b11
  } tpo_trig_type;
endpackage

// ---- hdl/tpo_regs.svh ----
// Register map, field positions and reset values for the timing pattern output unit.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH

`define TPO_ADDR_W 5
`define TPO_OFS_MODE 5'h00
`define TPO_OFS_TRIG 5'h04
`define TPO_OFS_NEXT_LO 5'h08
`define TPO_OFS_NEXT_HI 5'h0C
`define TPO_OFS_EN_LO 5'h10
`define TPO_OFS_EN_HI 5'h14
`define TPO_OFS_PORT_LO 5'h18
`define TPO_OFS_PORT_HI 5'h1C

`define TPO_MODE_RESET 8'hF0
`define TPO_MODE_FIXED 8'hF0
`define TPO_TRIG_RESET 8'hFF
`define TPO_ZERO_RESET 8'h00
`define TPO_GROUPS 4
`define TPO_GROUP_W 4

`endif

// ---- hdl/tpo_top.sv ----
// Timing pattern output: copies staged next-data bits to port data on timer compare events.
// Assumes compare pulses are one sys_clk wide and synchronous; registers via classic Wishbone.
// Contract
// - Mode register resets to F0 and holds its contents otherwise.
// - Mode bits 7 to 4 ignore writes and read as one.
// - Mode bit 0 for a group: its outputs update at compare match A.
// - Mode bit 1: ones and zeros produced separately at matches A and B.
// - Pin is driven by pattern only when direction and enable are one; here pattern_pin_oe follows direction alone.
// - Pin starts at port data; events copy enabled next-data into port data.
// - Enabled input pin: port data read-only but still loaded on events.
// - Non-overlapping outputs fall at match B and rise at match A.
// - Rising edges lag falling edges by the timer register A margin.
// - Two-bit trigger select: 00 ch0, 01 ch1, 1x ch2; resets to 11.
// - Non-overlap: match A copies all enabled bits, match B only zeros.
// - Bits with enable zero are never copied at compare events.
`timescale 1ns/1ns
`include "tpo_regs.svh"

module tpo_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [2:0] cmp_a_pulse,
  input wire logic [2:0] cmp_b_pulse,
  input wire logic [7:0] port_low_dir,
  input wire logic [7:0] port_high_dir,
  input wire logic [15:0] pattern_pin_i,
  output logic [15:0] pattern_pin_o,
  output logic [15:0] pattern_pin_oe
);

  logic [3:0] overlap_sel;
  logic [7:0] group_overlap_mode;
  logic [7:0] trigger_select_reg;
  logic [7:0] next_pattern_low;
  logic [7:0] next_pattern_high;
  logic [7:0] next_enable_low;
  logic [7:0] next_enable_high;
  logic [15:0] next_pattern;
  logic [15:0] next_enable;
  logic [15:0] port_out;
  logic [15:0] next_port_out;
  logic [15:0] next_port_data;
  logic [15:0] port_wr_mask;
  logic [15:0] port_wr_data;
  logic [15:0] port_dir;
  logic [3:0] grp_a;
  logic [3:0] grp_b;
  logic wr_stb;
  logic rd_stb;
  logic wr_mode;
  logic wr_trig;
  logic wr_next_lo;
  logic wr_next_hi;
  logic wr_en_lo;
  logic wr_en_hi;
  logic acc;
  logic [`TPO_ADDR_W-1:0] ofs;
  logic mapped;
  logic [7:0] rd_byte;

  localparam logic [7:0] MODE_RST = `TPO_MODE_RESET;
  localparam logic [7:0] MODE_FIX = `TPO_MODE_FIXED;

  assign port_dir = {port_high_dir, port_low_dir};
  assign next_pattern = {next_pattern_high, next_pattern_low};
  assign next_enable = {next_enable_high, next_enable_low};
  // Upper nibble has no storage, so writes cannot reach it
  assign group_overlap_mode = {MODE_FIX[7:4], overlap_sel};

  // Bus decode
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign ofs = wb_adr_i[`TPO_ADDR_W-1:0];
  assign mapped = (wb_adr_i[31:`TPO_ADDR_W] == '0) && (ofs[1:0] == 2'b00);
  assign wr_stb = acc && wb_we_i && mapped && wb_sel_i[0];
  assign rd_stb = acc && !wb_we_i && mapped;

  // Offset match, shared by every write path
  function automatic logic hit(input logic [`TPO_ADDR_W-1:0] a,
      input logic [`TPO_ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // One strobe per register, except the two port registers, which use the per-bit write mask below
  assign wr_mode = wr_stb && hit(ofs, `TPO_OFS_MODE);
  assign wr_trig = wr_stb && hit(ofs, `TPO_OFS_TRIG);
  assign wr_next_lo = wr_stb && hit(ofs, `TPO_OFS_NEXT_LO);
  assign wr_next_hi = wr_stb && hit(ofs, `TPO_OFS_NEXT_HI);
  assign wr_en_lo = wr_stb && hit(ofs, `TPO_OFS_EN_LO);
  assign wr_en_hi = wr_stb && hit(ofs, `TPO_OFS_EN_HI);

  // Port read: output bits show the latch, input bits the pad
  function automatic logic [7:0] port_view(input logic [7:0] latch,
      input logic [7:0] pad, input logic [7:0] dir);
    port_view = (latch & dir) | (pad & ~dir);
  endfunction

  // Channel picked by a group's two-bit select field
  function automatic logic pick_ch(input logic [1:0] sel, input logic [2:0] ev);
    unique case (tpo_pkg::tpo_trig_type'(sel))
      tpo_pkg::tpo_trig_ch0: pick_ch = ev[0];
      tpo_pkg::tpo_trig_ch1: pick_ch = ev[1];
      tpo_pkg::tpo_trig_ch2, tpo_pkg::tpo_trig_ch2b: pick_ch = ev[2];
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < `TPO_GROUPS; g++) begin : gen_grp
      localparam int LO = g * `TPO_GROUP_W;
      logic [`TPO_GROUP_W-1:0] npat;
      logic [`TPO_GROUP_W-1:0] nen;
      logic [`TPO_GROUP_W-1:0] cur;
      logic [`TPO_GROUP_W-1:0] take_a;
      logic [`TPO_GROUP_W-1:0] take_b;
      logic [`TPO_GROUP_W-1:0] upd;
      assign npat = next_pattern[LO +: `TPO_GROUP_W];
      assign nen = next_enable[LO +: `TPO_GROUP_W];
      assign cur = port_out[LO +: `TPO_GROUP_W];
      assign grp_a[g] = pick_ch(trigger_select_reg[2*g +: 2], cmp_a_pulse);
      assign grp_b[g] = pick_ch(trigger_select_reg[2*g +: 2], cmp_b_pulse);
      // Match A loads every enabled bit in both modes
      assign take_a = (nen & npat) | (~nen & cur);
      // Only zeros move on match B, so rises wait for A: that wait is the margin
      assign take_b = cur & ~(nen & ~npat);
      always_comb begin
        upd = cur;
        if (grp_a[g]) begin
          upd = take_a;
        end else if (grp_b[g] && group_overlap_mode[g]) begin
          upd = take_b;
        end
      end
      assign next_port_out[LO +: `TPO_GROUP_W] = upd;
      // Overlap bit of this group
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          overlap_sel[g] <= MODE_RST[g];
        end else if (hw_standby) begin
          overlap_sel[g] <= MODE_RST[g];
        end else if (wr_mode) begin
          overlap_sel[g] <= wb_dat_i[g];
        end
      end
    end
  endgenerate

  // Software reaches a port bit only while its enable is clear and no event moves it
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : gen_bit
      localparam logic [`TPO_ADDR_W-1:0] PORT_OFS = (b < 8) ? `TPO_OFS_PORT_LO
          : `TPO_OFS_PORT_HI;
      assign port_wr_mask[b] = wr_stb && hit(ofs, PORT_OFS) && !next_enable[b]
          && (next_port_out[b] == port_out[b]);
      assign port_wr_data[b] = wb_dat_i[b % 8];
    end
  endgenerate
  assign next_port_data = (next_port_out & ~port_wr_mask)
      | (port_wr_data & port_wr_mask);

  // Trigger select, two bits per group
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_select_reg <= `TPO_TRIG_RESET;
    end else if (hw_standby) begin
      trigger_select_reg <= `TPO_TRIG_RESET;
    end else if (wr_trig) begin
      trigger_select_reg <= wb_dat_i[7:0];
    end
  end

  // Staged pattern, low byte; a late write misses the next event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_pattern_low <= `TPO_ZERO_RESET;
    end else if (hw_standby) begin
      next_pattern_low <= `TPO_ZERO_RESET;
    end else if (wr_next_lo) begin
      next_pattern_low <= wb_dat_i[7:0];
    end
  end

  // Staged pattern, high byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_pattern_high <= `TPO_ZERO_RESET;
    end else if (hw_standby) begin
      next_pattern_high <= `TPO_ZERO_RESET;
    end else if (wr_next_hi) begin
      next_pattern_high <= wb_dat_i[7:0];
    end
  end

  // Transfer enables, low byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_enable_low <= `TPO_ZERO_RESET;
    end else if (hw_standby) begin
      next_enable_low <= `TPO_ZERO_RESET;
    end else if (wr_en_lo) begin
      next_enable_low <= wb_dat_i[7:0];
    end
  end

  // Transfer enables, high byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_enable_high <= `TPO_ZERO_RESET;
    end else if (hw_standby) begin
      next_enable_high <= `TPO_ZERO_RESET;
    end else if (wr_en_hi) begin
      next_enable_high <= wb_dat_i[7:0];
    end
  end

  // Port data: compare transfer beats a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out <= {`TPO_ZERO_RESET, `TPO_ZERO_RESET};
    end else if (hw_standby) begin
      port_out <= {`TPO_ZERO_RESET, `TPO_ZERO_RESET};
    end else begin
      port_out <= next_port_data;
    end
  end

  // Pin copy of the port latch, so software writes show as well as events
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_pin_o <= 16'h0000;
    end else if (hw_standby) begin
      pattern_pin_o <= 16'h0000;
    end else begin
      pattern_pin_o <= next_port_data;
    end
  end

  // Pin drive follows direction; pattern and plain port share the data latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_pin_oe <= 16'h0000;
    end else begin
      pattern_pin_oe <= port_dir;
    end
  end

  always_comb begin
    unique case (ofs)
      `TPO_OFS_MODE: rd_byte = group_overlap_mode;
      `TPO_OFS_TRIG: rd_byte = trigger_select_reg;
      `TPO_OFS_NEXT_LO: rd_byte = next_pattern[7:0];
      `TPO_OFS_NEXT_HI: rd_byte = next_pattern[15:8];
      `TPO_OFS_EN_LO: rd_byte = next_enable[7:0];
      `TPO_OFS_EN_HI: rd_byte = next_enable[15:8];
      // Input pins read the pad, output pins the latch
      `TPO_OFS_PORT_LO: rd_byte = port_view(port_out[7:0], pattern_pin_i[7:0], port_dir[7:0]);
      `TPO_OFS_PORT_HI: rd_byte = port_view(port_out[15:8], pattern_pin_i[15:8],
          port_dir[15:8]);
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait-free answer per request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc && mapped;
    end
  end

  // Unmapped or misaligned addresses get err, so a stray access never hangs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= acc && !mapped;
    end
  end

  // Read data stands only with its ack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_stb ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule // tpo_top
